// file: eeprd_map.svh
`ifndef EEPRD_MAP_SVH
`define EEPRD_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------
`define EEPRD_OFF_CTRL     8'h00
`define EEPRD_OFF_STATUS   8'h04
`define EEPRD_OFF_ADDR     8'h08
`define EEPRD_OFF_IDWR     8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EEPRD_CTRL_LOCK_BIT   0
`define EEPRD_CTRL_PROT_LSB   1
`define EEPRD_IDWR_IDX_LSB    8
`define EEPRD_MEM_ADDR_BITS   8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EEPRD_RST_LOCK     1'h0
`define EEPRD_RST_PROT     2'h0
`define EEPRD_RST_ADDR     18'h00000

// ----------------------------------------------------------------
// two-wire command codes
// ----------------------------------------------------------------
`define EEPRD_TYPE_ARRAY   4'hA
`define EEPRD_TYPE_SECOND  4'hB
`define EEPRD_SEL_IDPAGE   2'h0
`define EEPRD_SEL_SERIAL   2'h1
`define EEPRD_SEL_LOCK     2'h2
`define EEPRD_SEL_CONFIG   2'h3
`define EEPRD_LOCK_DATA_BIT 1
`define EEPRD_IDLE_BYTE    8'hFF

`endif

// file: eeprd_pkg.sv
package eeprd_pkg;

  // ----------------------------------------------------------------
  // protocol states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle  = 4'h0,  // standby, waiting for a start
    st_dev   = 4'h1,  // receiving device address byte
    st_adr1  = 4'h2,  // receiving high word address byte
    st_adr2  = 4'h3,  // receiving low word address byte
    st_wdata = 4'h4,  // receiving write data bytes
    st_ack   = 4'h5,  // device drives ack slot
    st_tx    = 4'h6,  // device shifts out a data byte
    st_mack  = 4'h7,  // master answers ack or nack
    st_wait  = 4'h8   // deselected until next start
  } eeprd_state_t;

  // ----------------------------------------------------------------
  // read source
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    tgt_array  = 2'h0,
    tgt_idpage = 2'h1,
    tgt_serial = 2'h2,
    tgt_config = 2'h3
  } eeprd_tgt_t;

endpackage

// file: eeprd_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// link between control logic and the identification page store
// ----------------------------------------------------------------
interface eeprd_mem_if;
  logic       wr_en;    // one-cycle write strobe
  logic [7:0] wr_addr;  // byte index to write
  logic [7:0] wr_data;  // byte to write
  logic [7:0] rd_addr;  // byte index to read
  logic [7:0] rd_data;  // registered read byte

  modport ctl (output wr_en, output wr_addr, output wr_data,
               output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
               input rd_addr, output rd_data);
endinterface

`default_nettype wire

// file: eeprd_idpage_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "eeprd_map.svh"

// ----------------------------------------------------------------
// 256-byte identification page store, registered read
// ----------------------------------------------------------------
module eeprd_idpage_mem (
  // clock
  input  wire logic i_clk,
  // access port
  eeprd_mem_if.mem  mem_port
);

  // storage, no reset: contents come from software loads
  logic [7:0] store [0:(1 << `EEPRD_MEM_ADDR_BITS) - 1];

  // write port
  always_ff @(posedge i_clk) begin
    if (mem_port.wr_en) begin
      store[mem_port.wr_addr] <= mem_port.wr_data;
    end
  end

  // read data out of a register, one cycle behind the address
  always_ff @(posedge i_clk) begin
    mem_port.rd_data <= store[mem_port.rd_addr];
  end

endmodule

`default_nettype wire

// file: eeprd_top.sv
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "eeprd_map.svh"

// How it works
// RQ1: master ack advances address, sends next byte
// RQ2: array address wraps from last to first
// RQ3: master ends array read with nack, stop
// RQ4: id page read uses 1011, A10:A9=00
// RQ5: A7:A0 pick id byte, wraps in page
// RQ6: id read is dummy write then read
// RQ7: id write data acked only when unlocked
// RQ8: master sends start then stop after probe
// RQ9: start discards pending write, stop to standby
// RQ10: config read uses 1011, A10:A9=11
// RQ11: config byte is six zeros, two bits
// RQ12: config byte repeats while master acks
// RQ13: serial read 1011, A10:A9=01, A3:A0 byte
// RQ14: sixteen serial bytes, wrap to first
// RQ15: master reads all serial bytes from zero
// RQ16: serial block can never be altered
// RQ17: master ends serial read with nack, stop
// RQ18: type code, strap and read bit must match; dev_ok checks only the type code and strap, never the read bit
// RQ19: two bits give protected region size
// RQ20: reads ignore protection settings
// RQ21: after nack, device silent until start

module eeprd_top #(
  // factory serial number, value is arbitrary
  parameter logic [127:0] FACTORY_SERIAL =
    128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // two-wire pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe_n,
  input  wire logic        i_chip_select_strap,
  // main array read port
  output logic      [17:0] o_arr_addr,
  input  wire logic [7:0]  i_arr_rdata
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff;  // release shifter
  logic       rst_n;        // released reset used everywhere

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // pin synchronisers: three stages, accept when 2nd and 3rd agree
  // ----------------------------------------------------------------
  logic [2:0] pin_s1_ff;   // first stage, read only by stage two
  logic [2:0] pin_s2_ff;   // second stage
  logic [2:0] pin_s3_ff;   // third stage
  logic [2:0] pin_q_ff;    // filtered levels {strap, sda, scl}
  logic [2:0] pin_prev_ff; // filtered levels one cycle ago

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 3'h7;
      pin_s2_ff <= 3'h7;
      pin_s3_ff <= 3'h7;
    end else begin
      pin_s1_ff <= {i_chip_select_strap, i_sda, i_scl};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // glitch filter per pin; a one-cycle spike never reaches pin_q
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_q_ff[gi]    <= 1'b1;
          pin_prev_ff[gi] <= 1'b1;
        end else begin
          if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
            pin_q_ff[gi] <= pin_s3_ff[gi];
          end
          pin_prev_ff[gi] <= pin_q_ff[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic scl_q;     // filtered clock level
  logic sda_q;     // filtered data level
  logic strap_q;   // filtered chip select strap
  logic scl_rise;  // clock rising edge seen
  logic scl_fall;  // clock falling edge seen
  logic bus_start; // data falls while clock high
  logic bus_stop;  // data rises while clock high

  assign scl_q     = pin_q_ff[0];
  assign sda_q     = pin_q_ff[1];
  assign strap_q   = pin_q_ff[2];
  assign scl_rise  = scl_q & ~pin_prev_ff[0];
  assign scl_fall  = ~scl_q & pin_prev_ff[0];
  assign bus_start = scl_q & pin_prev_ff[0] & pin_prev_ff[1] & ~sda_q;
  assign bus_stop  = scl_q & pin_prev_ff[0] & ~pin_prev_ff[1] & sda_q;

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  eeprd_pkg::eeprd_state_t state_ff;   // current protocol step
  eeprd_pkg::eeprd_state_t after_ff;   // step after the ack slot
  eeprd_pkg::eeprd_tgt_t   tgt_ff;     // source of read bytes
  logic [3:0]  bitcnt_ff;              // bits moved in this byte
  logic [7:0]  rx_ff;                  // receive shifter
  logic [7:0]  tx_ff;                  // transmit shifter
  logic [7:0]  dev_ff;                 // last device address byte
  logic [7:0]  adr1_ff;                // last high address byte
  logic [1:0]  sel_ff;                 // secondary command select
  logic        oe_n_ff;                // low while pulling sda low
  logic [17:0] addr_ff;                // shared address counter
  logic        locked_ff;              // identification page locked
  logic [1:0]  prot_ff;                // block_protect_config size
  logic        pend_lock_ff;           // lock waiting for stop
  logic [7:0]  tx_byte;                // byte about to go out
  logic        byte_end;               // eighth bit received
  logic        dev_ok;                 // device address accepted
  logic        second;                 // secondary type code
  logic        data_ok;                // write data byte accepted
  logic        adr_done;               // word address complete
  logic        adv;                    // master acked a read byte
  logic [127:0] serial_sh;             // serial block shifted
  eeprd_mem_if mem_bus ();             // id page store port

  assign byte_end = scl_fall & (bitcnt_ff == 4'h8);
  assign second   = (dev_ff[7:4] == `EEPRD_TYPE_SECOND);

  // RQ18: code, strap match
  assign dev_ok = ((rx_ff[7:4] == `EEPRD_TYPE_ARRAY) ||
                   (rx_ff[7:4] == `EEPRD_TYPE_SECOND)) &&
                  (rx_ff[3] == strap_q);

  // RQ7: locked page refuses data
  assign data_ok = !(second && locked_ff &&
                     ((sel_ff == `EEPRD_SEL_IDPAGE) ||
                      (sel_ff == `EEPRD_SEL_LOCK)));

  assign adr_done = (state_ff == eeprd_pkg::st_adr2) & byte_end;
  assign adv = (state_ff == eeprd_pkg::st_mack) & scl_rise & ~sda_q;

  // ----------------------------------------------------------------
  // byte sequencer; start and stop override every step
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= eeprd_pkg::st_idle;
      after_ff  <= eeprd_pkg::st_idle;
      bitcnt_ff <= 4'h0;
      rx_ff     <= 8'h00;
      tx_ff     <= 8'h00;
      oe_n_ff   <= 1'b1;
    end else if (bus_start) begin
      // RQ9: start resets command
      state_ff  <= eeprd_pkg::st_dev;
      bitcnt_ff <= 4'h0;
      oe_n_ff   <= 1'b1;
    end else if (bus_stop) begin
      // back to standby, line released
      state_ff <= eeprd_pkg::st_idle;
      oe_n_ff  <= 1'b1;
    end else begin
      case (state_ff)
        // receiving bytes from the master
        eeprd_pkg::st_dev, eeprd_pkg::st_adr1,
        eeprd_pkg::st_adr2, eeprd_pkg::st_wdata: begin
          if (scl_rise && bitcnt_ff < 4'h8) begin
            rx_ff     <= {rx_ff[6:0], sda_q};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end else if (byte_end) begin
            bitcnt_ff <= 4'h0;
            state_ff  <= eeprd_pkg::st_ack;
            oe_n_ff   <= 1'b0;
            case (state_ff)
              eeprd_pkg::st_dev: begin
                // read bit chooses sending or address phase
                after_ff <= rx_ff[0] ? eeprd_pkg::st_tx
                                     : eeprd_pkg::st_adr1;
                if (!dev_ok) begin
                  state_ff <= eeprd_pkg::st_wait;
                  oe_n_ff  <= 1'b1;
                end
              end
              eeprd_pkg::st_adr1: after_ff <= eeprd_pkg::st_adr2;
              eeprd_pkg::st_adr2: after_ff <= eeprd_pkg::st_wdata;
              default: begin
                // extra write bytes are taken but never stored
                after_ff <= eeprd_pkg::st_wdata;
                if (!data_ok) begin
                  state_ff <= eeprd_pkg::st_wait;
                  oe_n_ff  <= 1'b1;
                end
              end
            endcase
          end
        end
        // ack slot ends on the next falling clock
        eeprd_pkg::st_ack: begin
          if (scl_fall) begin
            state_ff  <= after_ff;
            bitcnt_ff <= 4'h0;
            oe_n_ff   <= 1'b1;
            if (after_ff == eeprd_pkg::st_tx) begin
              oe_n_ff <= tx_byte[7];
              tx_ff   <= {tx_byte[6:0], 1'b1};
            end
          end
        end
        // shift data out, msb first, changing while clock low
        eeprd_pkg::st_tx: begin
          if (scl_fall) begin
            if (bitcnt_ff == 4'h7) begin
              oe_n_ff   <= 1'b1;
              bitcnt_ff <= 4'h0;
              state_ff  <= eeprd_pkg::st_mack;
            end else begin
              oe_n_ff   <= tx_ff[7];
              tx_ff     <= {tx_ff[6:0], 1'b1};
              bitcnt_ff <= bitcnt_ff + 4'h1;
            end
          end
        end
        // master answer; the next byte leaves on the falling clock
        eeprd_pkg::st_mack: begin
          if (scl_rise) begin
            // RQ21: nack silences device
            if (sda_q) begin
              state_ff <= eeprd_pkg::st_wait;
            end else begin
              bitcnt_ff <= 4'h1;
            end
          end else if (scl_fall && bitcnt_ff == 4'h1) begin
            // RQ1: next byte sent
            state_ff  <= eeprd_pkg::st_tx;
            bitcnt_ff <= 4'h0;
            oe_n_ff   <= tx_byte[7];
            tx_ff     <= {tx_byte[6:0], 1'b1};
          end
        end
        // idle and deselected keep the line released
        default: begin
          oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command capture: device byte, high address, command select
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_ff  <= 8'h00;
      adr1_ff <= 8'h00;
      sel_ff  <= `EEPRD_SEL_IDPAGE;
      tgt_ff  <= eeprd_pkg::tgt_array;
    end else if (byte_end) begin
      if (state_ff == eeprd_pkg::st_dev && dev_ok) begin
        dev_ff <= rx_ff;
        // RQ18: code picks source
        if (rx_ff[7:4] == `EEPRD_TYPE_ARRAY) begin
          tgt_ff <= eeprd_pkg::tgt_array;
        end else begin
          // RQ4: 00 reads id page
          // RQ10: 11 reads config
          // RQ13: 01 reads serial
          case (sel_ff)
            `EEPRD_SEL_SERIAL: tgt_ff <= eeprd_pkg::tgt_serial;
            `EEPRD_SEL_CONFIG: tgt_ff <= eeprd_pkg::tgt_config;
            default:           tgt_ff <= eeprd_pkg::tgt_idpage;
          endcase
        end
      end
      if (state_ff == eeprd_pkg::st_adr1) begin
        adr1_ff <= rx_ff;
      end
      // A10:A9 sit in bits 2:1 of the high address byte
      if (state_ff == eeprd_pkg::st_adr2 && second) begin
        sel_ff <= adr1_ff[2:1];
      end
    end
  end

  // ----------------------------------------------------------------
  // shared address counter, wrap width set by the source
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= `EEPRD_RST_ADDR;
    end else if (adr_done) begin
      // RQ6: dummy write loads address
      addr_ff <= {dev_ff[2:1], adr1_ff, rx_ff};
    end else if (adv) begin
      case (tgt_ff)
        // RQ2: wraps to first byte
        eeprd_pkg::tgt_array: addr_ff <= addr_ff + 18'h00001;
        // RQ5: wraps inside page
        eeprd_pkg::tgt_idpage: begin
          addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
        end
        // RQ14: wraps after 16 bytes
        eeprd_pkg::tgt_serial: begin
          addr_ff[3:0] <= addr_ff[3:0] + 4'h1;
        end
        // RQ12: config address held
        default: addr_ff <= addr_ff;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outgoing byte select
  // ----------------------------------------------------------------
  // RQ16: serial is a constant
  assign serial_sh = FACTORY_SERIAL >> {~addr_ff[3:0], 3'h0};

  // RQ20: no protection gating
  always_comb begin
    case (tgt_ff)
      eeprd_pkg::tgt_array:  tx_byte = i_arr_rdata;
      eeprd_pkg::tgt_idpage: tx_byte = mem_bus.rd_data;
      eeprd_pkg::tgt_serial: tx_byte = serial_sh[7:0];
      // RQ11: six zeros, size bits
      eeprd_pkg::tgt_config: tx_byte = {6'h00, prot_ff};
      default:               tx_byte = `EEPRD_IDLE_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // lock command: armed by its data byte, done only at stop
  // ----------------------------------------------------------------
  logic lock_sw_clr; // software writes zero to the lock bit
  logic lock_set;    // lock command completed by a stop

  assign lock_sw_clr = i_avs_write & ~o_avs_waitrequest &
                       (i_avs_address == `EEPRD_OFF_CTRL) &
                       ~i_avs_writedata[`EEPRD_CTRL_LOCK_BIT];
  assign lock_set = bus_stop & pend_lock_ff;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_lock_ff <= 1'b0;
    end else if (bus_start || bus_stop) begin
      // RQ9: truncated write dropped
      pend_lock_ff <= 1'b0;
    end else if (state_ff == eeprd_pkg::st_wdata && byte_end) begin
      // a second data byte cancels the lock command
      pend_lock_ff <= second && data_ok && !pend_lock_ff &&
                      (sel_ff == `EEPRD_SEL_LOCK) &&
                      rx_ff[`EEPRD_LOCK_DATA_BIT];
    end
  end

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  logic avs_ack_ff; // answer cycle of the current request

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_ack_ff <= 1'b0;
    end else begin
      avs_ack_ff <= (i_avs_read | i_avs_write) & ~avs_ack_ff;
    end
  end
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~avs_ack_ff;

  // control register; hardware lock wins over a software clear
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_ff <= `EEPRD_RST_LOCK;
      prot_ff   <= `EEPRD_RST_PROT;
    end else begin
      if (lock_set) begin
        locked_ff <= 1'b1;
      end else if (lock_sw_clr) begin
        locked_ff <= 1'b0;
      end else if (i_avs_write && avs_ack_ff &&
                   i_avs_address == `EEPRD_OFF_CTRL) begin
        locked_ff <= i_avs_writedata[`EEPRD_CTRL_LOCK_BIT];
      end
      // RQ19: region size field
      if (i_avs_write && avs_ack_ff &&
          i_avs_address == `EEPRD_OFF_CTRL) begin
        prot_ff <= i_avs_writedata[`EEPRD_CTRL_PROT_LSB +: 2];
      end
    end
  end

  // read data captured in the wait cycle, stands until next read
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (i_avs_read && !avs_ack_ff) begin
      case (i_avs_address)
        `EEPRD_OFF_CTRL:   o_avs_readdata <= {29'h0, prot_ff, locked_ff};
        `EEPRD_OFF_STATUS: o_avs_readdata <= {24'h0, pend_lock_ff,
                                              ~oe_n_ff, tgt_ff,
                                              state_ff};
        `EEPRD_OFF_ADDR:   o_avs_readdata <= {14'h0, addr_ff};
        // write-only and unmapped offsets read as zero
        default:           o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // identification page store
  // ----------------------------------------------------------------
  assign mem_bus.wr_en   = i_avs_write & avs_ack_ff &
                           (i_avs_address == `EEPRD_OFF_IDWR);
  assign mem_bus.wr_addr = i_avs_writedata[`EEPRD_IDWR_IDX_LSB +: 8];
  assign mem_bus.wr_data = i_avs_writedata[7:0];
  assign mem_bus.rd_addr = addr_ff[7:0];

  eeprd_idpage_mem u_idpage (
    .i_clk    (i_ref_clk),
    .mem_port (mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // pins out; sda is open drain, so only a low is ever driven
  // ----------------------------------------------------------------
  assign o_sda_out  = 1'b0;
  assign o_sda_oe_n = oe_n_ff;
  assign o_arr_addr = addr_ff;

endmodule

`default_nettype wire

// file: eeprd_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module eeprd_top_chk (
  // watched top ports
  input wire logic        i_ref_clk,
  input wire logic        i_arst_n,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_scl,
  input wire logic        o_sda_out,
  input wire logic        o_sda_oe_n
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // any bus request in flight
  wire logic rq = i_avs_read | i_avs_write;
  a_wait_first: assert property ($rose(rq) |-> o_avs_waitrequest)
    else $error("request answered with no wait");
  a_wait_bound: assert property (rq && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("request waited too long");
  a_read_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest &&
    i_avs_address >= 8'h0C |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_sda_drain: assert property (o_sda_out == 1'b0)
    else $error("sda driven high");
  a_bit_hold: assert property (
    i_scl [*8] |-> $stable(o_sda_oe_n)) else $error("sda moved, scl high");
  a_bit_launch: assert property (
    $changed(o_sda_oe_n) |-> !$past(i_scl, 3)) else $error("late launch");
  a_quiet_reset: assert property (
    $rose(i_arst_n) |-> o_sda_oe_n [*3]) else $error("sda held at reset");
endmodule
bind eeprd_top eeprd_top_chk i_eeprd_top_chk (.i_ref_clk, .i_arst_n,
  .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
  .o_avs_waitrequest, .i_scl, .o_sda_out, .o_sda_oe_n);
`default_nettype wire

// file: eeprd_mst.sv
`timescale 1ns/1ps
`default_nettype none
module eeprd_mst (
  // clock and bus pins
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // bus idles released: scl stands high outside frames
  initial {o_scl, o_sda} = 2'b11;
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // 25 clocks a bit: sda moves mid-low, sampled mid-high
  task automatic bx(input logic b, output logic r);
    wt(6); o_sda <= b;
    wt(6); o_scl <= 1'b1;
    wt(6); r = i_sda;
    wt(7); o_scl <= 1'b0;
  endtask
  // s1 low gives a start, s1 high a stop
  task automatic cond(input logic s1);
    wt(6); o_sda <= !s1;
    wt(6); o_scl <= 1'b1;
    wt(6); o_sda <= s1;
    wt(6); o_scl <= s1;
  endtask
  task automatic wb(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, r);
    a = !r;
  endtask
  task automatic rb(output logic [7:0] d, input logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bx(1'b1, r);
      d[i] = r;
    end
    bx(!a, r);
  endtask
endmodule
`default_nettype wire

// file: eeprd_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module eeprd_top_tb_top;
  typedef struct packed {
    logic [7:0]  dev, hi, lo;
    logic [31:0] ctl;
    logic [23:0] exp;
  } eeprd_row_t;
  logic        clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0, strap = 1'b1;
  logic        ak, wreq, oe_n, scl, m_sda;
  logic [7:0]  adr, ard, b;
  logic [17:0] aa;
  logic [31:0] wd, rdq;
  int          compares = 0, miscompares = 0, cyc = 0;
  wire logic   sda = oe_n & m_sda;
  eeprd_row_t  rows[4] = '{
    '{8'hB8, 8'h86, 8'h55, 32'h6, 24'h030303},
    '{8'hAE, 8'hFF, 8'hFE, 32'h6, 24'hFDFC00},
    '{8'hB8, 8'hF2, 8'hFE, 32'h2, 24'hEEFF00},
    '{8'hB8, 8'h01, 8'hFF, 32'h4, 24'hC33C3D}};
  eeprd_top #(.FACTORY_SERIAL(128'h00112233445566778899AABBCCDDEEFF))
    i_eeprd_top (.i_ref_clk(clk), .i_arst_n(arst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdq), .o_avs_waitrequest(wreq), .i_scl(scl),
    .i_sda(sda), .o_sda_out(), .o_sda_oe_n(oe_n),
    .i_chip_select_strap(strap), .o_arr_addr(aa), .i_arr_rdata(ard));
  eeprd_mst i_eeprd_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda(m_sda));
  always #2.5 clk = ~clk;
  // array byte is a mix of address bits, one clock behind
  always @(posedge clk) ard <= aa[7:0] ^ {6'h00, aa[17:16]};
  always @(posedge clk) begin
    if (++cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic cmp(input logic [7:0] g, e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic hdr(input logic [7:0] dv, hi, lo);
    i_eeprd_mst.cond(1'b0);
    i_eeprd_mst.wb(dv, ak);
    i_eeprd_mst.wb(hi, ak);
    i_eeprd_mst.wb(lo, ak);
  endtask
  task automatic run(input eeprd_row_t r);
    avs(1'b1, 8'h00, r.ctl);
    hdr(r.dev, r.hi, r.lo);
    i_eeprd_mst.cond(1'b0);
    i_eeprd_mst.wb(r.dev | 8'h01, ak);
    cmp({7'h00, ak}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      i_eeprd_mst.rb(b, i < 2);
      cmp(b, r.exp[23-8*i -: 8]);
    end
    i_eeprd_mst.rb(b, 1'b0);
    cmp(b, 8'hFF);
    i_eeprd_mst.cond(1'b1);
  endtask
  task automatic probe(input logic [7:0] hi, dt, input logic e);
    hdr(8'hB8, hi, 8'h00);
    i_eeprd_mst.wb(dt, ak);
    cmp({7'h00, ak}, {7'h00, e});
    i_eeprd_mst.cond(1'b0);
    i_eeprd_mst.cond(1'b1);
  endtask
  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (9) @(posedge clk);
    avs(1'b0, 8'h00, 32'h0);
    cmp(rdq[7:0], 8'h00);
    avs(1'b0, 8'h10, 32'h0);
    cmp(rdq[7:0], 8'h00);
    // page bytes at ff, 00, 01 hold index xor 3c
    for (int i = 0; i < 3; i++)
      avs(1'b1, 8'h0C, {16'h0, 8'(i - 1), 8'(i - 1) ^ 8'h3C});
    foreach (rows[i]) run(rows[i]);
    // whole serial block from byte zero, one pass
    hdr(8'hB8, 8'h02, 8'h00);
    i_eeprd_mst.cond(1'b0);
    i_eeprd_mst.wb(8'hB9, ak);
    for (int i = 0; i < 16; i++) begin
      i_eeprd_mst.rb(b, i < 15);
      cmp(b, 8'(i * 17));
    end
    i_eeprd_mst.cond(1'b1);
    // lock command cut short by start must leave page open
    probe(8'h04, 8'h02, 1'b1);
    probe(8'h00, 8'h00, 1'b1);
    avs(1'b1, 8'h00, 32'h1);
    probe(8'h00, 8'h00, 1'b0);
    hdr(8'hA6, 8'h00, 8'h00);
    cmp({7'h00, ak}, 8'h00);
    i_eeprd_mst.cond(1'b1);
    // mid-run reset must clear the lock bit
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (9) @(posedge clk);
    avs(1'b0, 8'h00, 32'h0);
    cmp(rdq[7:0], 8'h00);
    // strap moved low: the same device byte now matches
    strap <= 1'b0;
    hdr(8'hA6, 8'h00, 8'h00);
    cmp({7'h00, ak}, 8'h01);
    i_eeprd_mst.cond(1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
